// ==== verilog/ccrd_pkg.sv ====
// Package of constants and types for the column clock and reset distribution block
package ccrd_pkg;

	// ----------------------------------------------------------------
	// Array size
	// ----------------------------------------------------------------
	localparam int CCRD_NUM_COLUMNS_DEF = 8;
	localparam int CCRD_SEL_W = 2;

	// ----------------------------------------------------------------
	// Source selection shared by the clock and the reset selectors
	// ----------------------------------------------------------------
	typedef enum logic [CCRD_SEL_W-1:0] {
		CCRD_SRC_GLOBAL,
		CCRD_SRC_EXPRESS,
		CCRD_SRC_CELL,
		CCRD_SRC_CONST
	} ccrd_src_type;

	// ----------------------------------------------------------------
	// Power-up sequencing
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CCRD_PU_HOLD,
		CCRD_PU_RUN
	} ccrd_pu_type;

	// ----------------------------------------------------------------
	// Reset values and levels
	// ----------------------------------------------------------------
	localparam ccrd_src_type CCRD_CLK_SEL_RST = CCRD_SRC_CONST;
	localparam ccrd_src_type CCRD_RST_SEL_RST = CCRD_SRC_CONST;
	localparam logic CCRD_CLK_STATIC = 1'h1;
	localparam logic CCRD_RST_ASSERTED = 1'h0;
	localparam logic CCRD_RST_IDLE = 1'h1;
	localparam logic CCRD_SYNC_RST = 1'h0;
	localparam int CCRD_HOLD_W = 8;
	localparam logic [CCRD_HOLD_W-1:0] CCRD_POWERUP_HOLD_CYCLES = 8'h10;

endpackage : ccrd_pkg

// ==== verilog/ccrd_col_if.sv ====
// Interface between the distribution top and one column selector
`timescale 1ns/1ps
interface ccrd_col_if;
	import ccrd_pkg::*;

	ccrd_src_type clk_sel;
	ccrd_src_type rst_sel;
	logic global_clock;
	logic global_reset_b;
	logic express_clock;
	logic express_reset_b;
	logic top_cell_a;
	logic bottom_cell_a;
	logic powerup_hold;
	logic column_clock;
	logic column_reset_b;

	modport column (
		input clk_sel,
		input rst_sel,
		input global_clock,
		input global_reset_b,
		input express_clock,
		input express_reset_b,
		input top_cell_a,
		input bottom_cell_a,
		input powerup_hold,
		output column_clock,
		output column_reset_b
	);

	modport ctrl (
		output clk_sel,
		output rst_sel,
		output global_clock,
		output global_reset_b,
		output express_clock,
		output express_reset_b,
		output top_cell_a,
		output bottom_cell_a,
		output powerup_hold,
		input column_clock,
		input column_reset_b
	);

endinterface : ccrd_col_if

// ==== verilog/ccrd_column_sel.sv ====
// Clock and reset source selectors of one column
`timescale 1ns/1ps
module ccrd_column_sel (
	input wire logic i_clk,
	input wire logic i_rst_b,
	ccrd_col_if.column col
);
	import ccrd_pkg::*;

	// ----------------------------------------------------------------
	// Source selection
	// ----------------------------------------------------------------
	logic next_column_clock;
	logic next_column_reset_b;
	logic sel_reset_b;

	assign next_column_clock =
		(col.clk_sel == CCRD_SRC_GLOBAL)  ? col.global_clock :
		(col.clk_sel == CCRD_SRC_EXPRESS) ? col.express_clock :
		(col.clk_sel == CCRD_SRC_CELL)    ? col.top_cell_a :
		CCRD_CLK_STATIC; // [RULE2] [RULE3]

	assign sel_reset_b =
		(col.rst_sel == CCRD_SRC_GLOBAL)  ? col.global_reset_b :
		(col.rst_sel == CCRD_SRC_EXPRESS) ? col.express_reset_b :
		(col.rst_sel == CCRD_SRC_CELL)    ? col.bottom_cell_a :
		CCRD_RST_IDLE; // [RULE7] [RULE10]

	// Power-up overrides whatever the column has selected
	assign next_column_reset_b = col.powerup_hold ? CCRD_RST_ASSERTED : sel_reset_b; // [RULE11]

	// ----------------------------------------------------------------
	// Output flops
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			col.column_clock <= CCRD_CLK_STATIC;
			col.column_reset_b <= CCRD_RST_ASSERTED; // [RULE11]
		end else begin
			col.column_clock <= next_column_clock; // [RULE1]
			col.column_reset_b <= next_column_reset_b; // [RULE6]
		end
	end

endmodule : ccrd_column_sel

// ==== verilog/ccrd_top.sv ====
// Column clock and asynchronous reset distribution for the logic cell array
// Summary of operation
// RULE1: Every column has its own four-input clock selector, clocked independently.
// RULE2: Clock choices: global clock pin, express bus, top cell A output, constant 1.
// RULE3: Constant 1 holds the column clock static to save power.
// RULE4: Global clock pin also feeds the A input of both upper corner cells.
// RULE5: Express bus choice spreads a secondary clock to several columns.
// RULE6: Every column has its own four-input reset selector, reset independently.
// RULE7: Reset choices: global reset pin, express bus, bottom cell A output, constant 1.
// RULE8: Selected column reset clears cell flip-flops asynchronously, no clock edge needed.
// RULE9: Global reset pin also feeds the A input of both lower corner cells.
// RULE10: Columns needing no reset select constant 1, reset never active.
// RULE11: At power-up every array register is forced into reset regardless of selection.
// RULE12: Registers change on rising column clock edge; global clock ignores configuration.
// RULE13: Global reset pin drives global reset line, untouched by configuration.
// RULE14: Each column holds 2-bit clock and reset selects, loaded and then static.
`timescale 1ns/1ps
module ccrd_top #(
	parameter int NUM_COLUMNS = ccrd_pkg::CCRD_NUM_COLUMNS_DEF,
	parameter int COL_W = (NUM_COLUMNS > 1) ? $clog2(NUM_COLUMNS) : 1
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_global_clock,
	input wire logic i_global_reset_b,
	input wire logic [NUM_COLUMNS-1:0] i_express_clock,
	input wire logic [NUM_COLUMNS-1:0] i_express_reset_b,
	input wire logic [NUM_COLUMNS-1:0] i_top_cell_a,
	input wire logic [NUM_COLUMNS-1:0] i_bottom_cell_a,
	input wire logic i_cfg_write,
	input wire logic [COL_W-1:0] i_cfg_col,
	input wire ccrd_pkg::ccrd_src_type i_cfg_clk_sel,
	input wire ccrd_pkg::ccrd_src_type i_cfg_rst_sel,
	input wire logic i_cfg_commit,
	input wire logic [COL_W-1:0] i_cfg_rd_col,
	output logic [NUM_COLUMNS-1:0] o_column_clock,
	output logic [NUM_COLUMNS-1:0] o_column_reset_b,
	output logic o_upper_left_corner_clock_tap,
	output logic o_upper_right_corner_clock_tap,
	output logic o_lower_left_corner_reset_tap,
	output logic o_lower_right_corner_reset_tap,
	output ccrd_pkg::ccrd_src_type o_cfg_rd_clk_sel,
	output ccrd_pkg::ccrd_src_type o_cfg_rd_rst_sel,
	output logic [NUM_COLUMNS-1:0] o_column_clock_stopped,
	output logic o_powerup_busy
);
	import ccrd_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Every source arrives from outside this clock, so each passes two
	// flops; the first stage is read by the second stage only.
	localparam int SYNC_W = 2 + 4 * NUM_COLUMNS;

	logic [SYNC_W-1:0] sync_in;
	logic [SYNC_W-1:0] sync_meta;
	logic [SYNC_W-1:0] sync_out;

	assign sync_in = {i_bottom_cell_a, i_top_cell_a, i_express_reset_b,
		i_express_clock, i_global_reset_b, i_global_clock};

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sync_meta <= {SYNC_W{CCRD_SYNC_RST}};
			sync_out <= {SYNC_W{CCRD_SYNC_RST}};
		end else begin
			sync_meta <= sync_in;
			sync_out <= sync_meta;
		end
	end

	logic global_clock_s;
	logic global_reset_b_s;
	logic [NUM_COLUMNS-1:0] express_clock_s;
	logic [NUM_COLUMNS-1:0] express_reset_b_s;
	logic [NUM_COLUMNS-1:0] top_cell_a_s;
	logic [NUM_COLUMNS-1:0] bottom_cell_a_s;

	assign global_clock_s = sync_out[0];
	assign global_reset_b_s = sync_out[1];
	assign express_clock_s = sync_out[2 +: NUM_COLUMNS];
	assign express_reset_b_s = sync_out[2 + NUM_COLUMNS +: NUM_COLUMNS];
	assign top_cell_a_s = sync_out[2 + 2 * NUM_COLUMNS +: NUM_COLUMNS];
	assign bottom_cell_a_s = sync_out[2 + 3 * NUM_COLUMNS +: NUM_COLUMNS];

	// ----------------------------------------------------------------
	// Power-up hold
	// ----------------------------------------------------------------
	// The hold keeps every column reset asserted for a while after the
	// device reset releases, so the array starts clean even when a
	// column has selected constant 1 or a quiet cell output.
	ccrd_pu_type pu_state;
	ccrd_pu_type next_pu_state;
	logic [CCRD_HOLD_W-1:0] pu_count;
	logic [CCRD_HOLD_W-1:0] next_pu_count;
	logic pu_done;

	assign pu_done = (pu_count == CCRD_POWERUP_HOLD_CYCLES);
	assign next_pu_count = pu_done ? pu_count : pu_count + 8'h01;

	always_comb begin
		next_pu_state = pu_state;
		unique case (pu_state)
			CCRD_PU_HOLD: begin
				if (pu_done) begin
					next_pu_state = CCRD_PU_RUN;
				end
			end
			CCRD_PU_RUN: begin
				next_pu_state = CCRD_PU_RUN;
			end
			default: begin
				next_pu_state = CCRD_PU_HOLD;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pu_state <= CCRD_PU_HOLD; // [RULE11]
			pu_count <= '0;
		end else begin
			pu_state <= next_pu_state;
			pu_count <= next_pu_count;
		end
	end

	logic powerup_hold;

	assign powerup_hold = (pu_state != CCRD_PU_RUN); // [RULE11]
	assign o_powerup_busy = powerup_hold;

	// ----------------------------------------------------------------
	// Corner cell taps
	// ----------------------------------------------------------------
	// Taps follow the synchronised pins only; no configuration input
	// reaches them, so loading or committing never disturbs them.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_upper_left_corner_clock_tap <= CCRD_CLK_STATIC;
			o_upper_right_corner_clock_tap <= CCRD_CLK_STATIC;
			o_lower_left_corner_reset_tap <= CCRD_RST_ASSERTED;
			o_lower_right_corner_reset_tap <= CCRD_RST_ASSERTED;
		end else begin
			o_upper_left_corner_clock_tap <= global_clock_s; // [RULE4] [RULE12]
			o_upper_right_corner_clock_tap <= global_clock_s; // [RULE4]
			o_lower_left_corner_reset_tap <= global_reset_b_s; // [RULE9] [RULE13]
			o_lower_right_corner_reset_tap <= global_reset_b_s; // [RULE9]
		end
	end

	// ----------------------------------------------------------------
	// Per-column configuration and selectors
	// ----------------------------------------------------------------
	// Writes land in a shadow copy; the live selects change only on a
	// commit, so a partial reload never glitches a running column.
	ccrd_src_type shadow_clk_sel [NUM_COLUMNS];
	ccrd_src_type shadow_rst_sel [NUM_COLUMNS];
	ccrd_src_type live_clk_sel [NUM_COLUMNS];
	ccrd_src_type live_rst_sel [NUM_COLUMNS];

	genvar col_idx;
	generate
		for (col_idx = 0; col_idx < NUM_COLUMNS; col_idx++) begin : g_col
			logic cfg_hit;

			assign cfg_hit = i_cfg_write && (i_cfg_col == COL_W'(col_idx));

			always_ff @(posedge i_clk or negedge i_rst_b) begin
				if (!i_rst_b) begin
					shadow_clk_sel[col_idx] <= CCRD_CLK_SEL_RST;
					shadow_rst_sel[col_idx] <= CCRD_RST_SEL_RST;
				end else if (cfg_hit) begin
					shadow_clk_sel[col_idx] <= i_cfg_clk_sel; // [RULE14]
					shadow_rst_sel[col_idx] <= i_cfg_rst_sel; // [RULE14]
				end
			end

			// A write and a commit in one cycle commit the written value
			ccrd_src_type next_live_clk;
			ccrd_src_type next_live_rst;

			assign next_live_clk = cfg_hit ? i_cfg_clk_sel : shadow_clk_sel[col_idx];
			assign next_live_rst = cfg_hit ? i_cfg_rst_sel : shadow_rst_sel[col_idx];

			always_ff @(posedge i_clk or negedge i_rst_b) begin
				if (!i_rst_b) begin
					live_clk_sel[col_idx] <= CCRD_CLK_SEL_RST; // [RULE3]
					live_rst_sel[col_idx] <= CCRD_RST_SEL_RST;
				end else if (i_cfg_commit) begin
					live_clk_sel[col_idx] <= next_live_clk; // [RULE14]
					live_rst_sel[col_idx] <= next_live_rst; // [RULE14]
				end
			end

			ccrd_col_if col_bus ();

			assign col_bus.clk_sel = live_clk_sel[col_idx]; // [RULE1]
			assign col_bus.rst_sel = live_rst_sel[col_idx]; // [RULE6]
			assign col_bus.global_clock = global_clock_s; // [RULE12]
			assign col_bus.global_reset_b = global_reset_b_s; // [RULE13]
			assign col_bus.express_clock = express_clock_s[col_idx]; // [RULE5]
			assign col_bus.express_reset_b = express_reset_b_s[col_idx];
			assign col_bus.top_cell_a = top_cell_a_s[col_idx];
			assign col_bus.bottom_cell_a = bottom_cell_a_s[col_idx];
			assign col_bus.powerup_hold = powerup_hold;

			ccrd_column_sel u_column_sel (
				.i_clk(i_clk),
				.i_rst_b(i_rst_b),
				.col(col_bus.column)
			);

			// Column reset is a level; cell flops use it as an async clear
			assign o_column_clock[col_idx] = col_bus.column_clock; // [RULE12]
			assign o_column_reset_b[col_idx] = col_bus.column_reset_b; // [RULE8]
			assign o_column_clock_stopped[col_idx] =
				(live_clk_sel[col_idx] == CCRD_SRC_CONST); // [RULE3]
		end
	endgenerate

	// ----------------------------------------------------------------
	// Configuration readback
	// ----------------------------------------------------------------
	ccrd_src_type rd_clk_sel;
	ccrd_src_type rd_rst_sel;
	logic rd_in_range;

	assign rd_in_range = (int'(i_cfg_rd_col) < NUM_COLUMNS);
	assign rd_clk_sel = rd_in_range ? live_clk_sel[i_cfg_rd_col] : CCRD_CLK_SEL_RST;
	assign rd_rst_sel = rd_in_range ? live_rst_sel[i_cfg_rd_col] : CCRD_RST_SEL_RST;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_cfg_rd_clk_sel <= CCRD_CLK_SEL_RST;
			o_cfg_rd_rst_sel <= CCRD_RST_SEL_RST;
		end else begin
			o_cfg_rd_clk_sel <= rd_clk_sel;
			o_cfg_rd_rst_sel <= rd_rst_sel;
		end
	end

endmodule : ccrd_top

// ==== testbench/ccrd_top_monitor.sv ====
// Port-level assertion checker of the distribution top
`timescale 1ns/1ps
module ccrd_top_monitor #(
	parameter int NUM_COLUMNS = 8,
	parameter int COL_W = 3
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_global_clock,
	input wire logic i_global_reset_b,
	input wire logic [NUM_COLUMNS-1:0] i_express_clock,
	input wire logic i_cfg_write,
	input wire logic i_cfg_commit,
	input wire logic [COL_W-1:0] i_cfg_col,
	input wire ccrd_pkg::ccrd_src_type i_cfg_clk_sel,
	input wire logic [COL_W-1:0] i_cfg_rd_col,
	input wire logic [NUM_COLUMNS-1:0] o_column_clock,
	input wire logic [NUM_COLUMNS-1:0] o_column_reset_b,
	input wire logic o_upper_left_corner_clock_tap,
	input wire logic o_upper_right_corner_clock_tap,
	input wire logic o_lower_left_corner_reset_tap,
	input wire logic o_lower_right_corner_reset_tap,
	input wire ccrd_pkg::ccrd_src_type o_cfg_rd_clk_sel,
	input wire ccrd_pkg::ccrd_src_type o_cfg_rd_rst_sel,
	input wire logic [NUM_COLUMNS-1:0] o_column_clock_stopped,
	input wire logic o_powerup_busy
);
	import ccrd_pkg::*;
	// ----
	// Edges since reset release, saturating
	// ----
	logic [4:0] up;
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			up <= 5'h00;
		end else if (up != 5'h1F) begin
			up <= up + 5'h01;
		end
	end
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);
	tap_clk_follow_a: assert property (up > 5'h03 |->
		o_upper_left_corner_clock_tap == $past(i_global_clock, 3)
		&& o_upper_right_corner_clock_tap == o_upper_left_corner_clock_tap)
		else $error("clock taps off");
	tap_rst_follow_a: assert property (up > 5'h03 |->
		o_lower_left_corner_reset_tap == $past(i_global_reset_b, 3)
		&& o_lower_right_corner_reset_tap == o_lower_left_corner_reset_tap)
		else $error("reset taps off");
	powerup_hold_a: assert property (o_powerup_busy |-> o_column_reset_b == '0)
		else $error("column reset released during power-up");
	busy_span_a: assert property (up != 5'h10 |-> o_powerup_busy == (up < 5'h10))
		else $error("power-up hold length wrong");
	stop_static_a: assert property (
		(~o_column_clock & o_column_clock_stopped & $past(o_column_clock_stopped)) == '0)
		else $error("stopped column clock moved");
	commit_live_a: assert property (i_cfg_write && i_cfg_commit |=>
		o_column_clock_stopped[$past(i_cfg_col)] == ($past(i_cfg_clk_sel) == CCRD_SRC_CONST))
		else $error("commit not applied");
	select_hold_a: assert property (!i_cfg_commit |=> $stable(o_column_clock_stopped))
		else $error("live select changed without commit");
	clk_global_a: assert property (
		(o_cfg_rd_clk_sel == CCRD_SRC_GLOBAL && $stable(i_cfg_rd_col))[*2]
		|-> o_column_clock[i_cfg_rd_col] == o_upper_left_corner_clock_tap)
		else $error("column not on global clock");
	clk_express_a: assert property (
		(o_cfg_rd_clk_sel == CCRD_SRC_EXPRESS && $stable(i_cfg_rd_col))[*3]
		|-> o_column_clock[i_cfg_rd_col] == $past(i_express_clock[i_cfg_rd_col], 3))
		else $error("column not on express clock");
	rst_const_a: assert property (
		(o_cfg_rd_rst_sel == CCRD_SRC_CONST && $stable(i_cfg_rd_col) && !o_powerup_busy)[*3]
		|-> o_column_reset_b[i_cfg_rd_col])
		else $error("unreset column saw reset");
	cover property (o_cfg_rd_clk_sel == CCRD_SRC_EXPRESS);
	cover property ($fell(o_powerup_busy));
	cover property (o_column_clock_stopped != '0 && !o_powerup_busy);
endmodule : ccrd_top_monitor

// ==== testbench/ccrd_src_model.sv ====
// Behavioural clock and reset sources around the array
`timescale 1ns/1ps
module ccrd_src_model #(
	parameter int NUM_COLUMNS = 8
) (
	input wire logic i_run,
	input wire logic [2:0] i_rst_req,
	output logic o_global_clock,
	output logic o_global_reset_b,
	output logic [NUM_COLUMNS-1:0] o_express_clock,
	output logic [NUM_COLUMNS-1:0] o_express_reset_b,
	output logic [NUM_COLUMNS-1:0] o_top_cell_a,
	output logic [NUM_COLUMNS-1:0] o_bottom_cell_a
);
	// ----
	// Own timebase
	// ----
	// Offset keeps source edges off both system clock edges
	logic [4:0] ph = 5'h00;
	initial begin
		#1;
		forever #40 if (i_run) ph = ph + 5'h01;
	end
	// Clock and top cell A sources stand still while stopped; reset sources follow i_rst_req
	assign o_global_clock = ph[2];
	assign o_express_clock = {NUM_COLUMNS{ph[3]}} ^ NUM_COLUMNS'(8'h5A);
	assign o_top_cell_a = {NUM_COLUMNS{ph[4]}} ^ NUM_COLUMNS'(8'h33);
	assign o_global_reset_b = ~i_rst_req[0];
	assign o_express_reset_b = ~{NUM_COLUMNS{i_rst_req[1]}};
	assign o_bottom_cell_a = ~{NUM_COLUMNS{i_rst_req[2]}};
endmodule : ccrd_src_model

// ==== testbench/ccrd_top_tb.sv ====
// Self-checking testbench of the column clock and reset distribution
`timescale 1ns/1ps
module ccrd_top_tb;
	import ccrd_pkg::*;
	// ----
	// Signals
	// ----
	localparam int N = 8;
	logic i_clk = 1'h0;
	logic i_rst_b = 1'h0;
	logic run = 1'h0;
	logic wr = 1'h0;
	logic cm = 1'h0;
	logic [2:0] rq = 3'h0;
	logic [2:0] col = 3'h0;
	logic [2:0] rdc = 3'h0;
	ccrd_src_type csel = CCRD_SRC_CONST;
	ccrd_src_type rsel = CCRD_SRC_CONST;
	ccrd_src_type rdcs, rdrs;
	ccrd_src_type cs [N];
	ccrd_src_type rs [N];
	logic gck, grs, ul, ur, ll, lr, busy;
	logic [N-1:0] xck, xrs, tca, bca, cck, crs, stp;
	logic [4*N+1:0] h0, h1, h2;
	int err_count = 0;
	int num_checks = 0;
	always #25 i_clk = ~i_clk;
	// Source history, three edges deep like the two synchroniser flops plus the output flop
	always @(posedge i_clk) {h2, h1, h0} <= {h1, h0, gck, grs, xck, xrs, tca, bca};
	ccrd_top #(.NUM_COLUMNS(N)) ccrd_top_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_global_clock(gck), .i_global_reset_b(grs), .i_express_clock(xck),
		.i_express_reset_b(xrs), .i_top_cell_a(tca), .i_bottom_cell_a(bca),
		.i_cfg_write(wr), .i_cfg_col(col), .i_cfg_clk_sel(csel), .i_cfg_rst_sel(rsel),
		.i_cfg_commit(cm), .i_cfg_rd_col(rdc), .o_column_clock(cck), .o_column_reset_b(crs),
		.o_upper_left_corner_clock_tap(ul), .o_upper_right_corner_clock_tap(ur),
		.o_lower_left_corner_reset_tap(ll), .o_lower_right_corner_reset_tap(lr),
		.o_cfg_rd_clk_sel(rdcs), .o_cfg_rd_rst_sel(rdrs), .o_column_clock_stopped(stp),
		.o_powerup_busy(busy));
	ccrd_src_model #(.NUM_COLUMNS(N)) ccrd_src_model_i (.i_run(run), .i_rst_req(rq),
		.o_global_clock(gck), .o_global_reset_b(grs), .o_express_clock(xck),
		.o_express_reset_b(xrs), .o_top_cell_a(tca), .o_bottom_cell_a(bca));
	// ----
	// Helpers
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic pick(ccrd_src_type s, logic g, logic x, logic c);
		case (s)
			CCRD_SRC_GLOBAL: pick = g;
			CCRD_SRC_EXPRESS: pick = x;
			CCRD_SRC_CELL: pick = c;
			default: pick = 1'h1;
		endcase
	endfunction : pick
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : summarize
	// ----
	// Scenarios
	// ----
	task automatic t_reset();
		int n;
		n = 0;
		@(negedge i_clk);
		i_rst_b = 1'h0;
		repeat (6) @(negedge i_clk);
		chk({cck, crs, stp, rdcs, rdrs, busy, ll}, {24'hFF00FF, 6'h3E});
		for (int k = 0; k < N; k++) begin
			cs[k] = CCRD_SRC_CONST;
			rs[k] = CCRD_SRC_CONST;
		end
		i_rst_b = 1'h1;
		while (busy === 1'h1 && n < 40) begin
			@(negedge i_clk);
			n++;
		end
		chk(n, 17);
	endtask : t_reset
	task automatic t_cfg(input logic [2:0] c, input ccrd_src_type k, input ccrd_src_type r);
		{wr, cm, col, rdc} = {2'h3, c, c};
		csel = k;
		rsel = r;
		@(negedge i_clk);
		{wr, cm} = 2'h0;
		cs[c] = k;
		rs[c] = r;
		chk(stp[c], k == CCRD_SRC_CONST);
		@(negedge i_clk);
		chk({rdcs, rdrs}, {k, r});
	endtask : t_cfg
	// Shadow write alone must leave the live selects alone
	task automatic t_shadow();
		{wr, col} = {1'h1, 3'h0};
		csel = CCRD_SRC_CONST;
		rsel = CCRD_SRC_GLOBAL;
		@(negedge i_clk);
		wr = 1'h0;
		repeat (3) @(negedge i_clk);
		chk(stp[0], 1'h0);
		cm = 1'h1;
		@(negedge i_clk);
		cm = 1'h0;
		cs[0] = CCRD_SRC_CONST;
		rs[0] = CCRD_SRC_GLOBAL;
		chk(stp[0], 1'h1);
		@(negedge i_clk);
	endtask : t_shadow
	task automatic t_follow();
		logic [N-1:0] ec, er;
		run = 1'h1;
		for (int t = 0; t < 64; t++) begin
			@(negedge i_clk);
			for (int k = 0; k < N; k++) begin
				ec[k] = pick(cs[k], h2[4*N+1], h2[3*N+k], h2[N+k]);
				er[k] = pick(rs[k], h2[4*N], h2[2*N+k], h2[k]);
			end
			chk({cck, crs, ul, ur, ll, lr}, {ec, er, {2{h2[4*N+1]}}, {2{h2[4*N]}}});
			rq = 3'(t / 5);
			rdc = 3'(t / 8);
		end
		@(negedge i_clk);
		run = 1'h0;
		rq = 3'h0;
	endtask : t_follow
	initial begin
		t_reset();
		for (int k = 0; k < N; k++) begin
			t_cfg(3'(k), ccrd_src_type'(k % 4), ccrd_src_type'(3 - k % 4));
		end
		t_follow();
		t_shadow();
		t_follow();
		t_reset();
		summarize();
	end
	initial begin
		#(3000 * 50);
		err_count++;
		summarize();
	end
endmodule : ccrd_top_tb

bind ccrd_top ccrd_top_monitor #(.NUM_COLUMNS(NUM_COLUMNS), .COL_W(COL_W)) ccrd_top_monitor_i (
	.i_clk, .i_rst_b, .i_global_clock, .i_global_reset_b, .i_express_clock, .i_cfg_write,
	.i_cfg_commit, .i_cfg_col, .i_cfg_clk_sel, .i_cfg_rd_col, .o_column_clock,
	.o_column_reset_b, .o_upper_left_corner_clock_tap, .o_upper_right_corner_clock_tap,
	.o_lower_left_corner_reset_tap, .o_lower_right_corner_reset_tap, .o_cfg_rd_clk_sel,
	.o_cfg_rd_rst_sel, .o_column_clock_stopped, .o_powerup_busy);
